// *** logic/reset_cause_unit.sv ***
// reset-cause flags, brown-out event flags and rail responses
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "rstcause_defines.svh"
// ===========================================================
// Notes on behaviour
// [RULE_01] cause flags stay set until software clear or power-on reset
// [RULE_02] several causes since the last clear all read as set together
// [RULE_03] cause clear hits only masked bits; same cause sets again later
// [RULE_04] software should clear all causes after reading them
// [RULE_05] sleep with gating keeps only sleep-enabled peripherals running
// [RULE_06] one brown-out flag each for main, analogue and core rails
// [RULE_07] brown-out flags survive system resets, cleared only by software or por
// [RULE_08] brown-out clear hits exactly masked bits; write-back clears all
// [RULE_09] analogue brown-out does none, interrupt, nmi or reset
// [RULE_10] main brown-out does none, interrupt, nmi or reset
// [RULE_11] brown-out reset uses the brown-out reset-kind setting
// [RULE_12] each configurable event does full por or system reset
// [RULE_13] software reset keeps cause flags and adds the software flag
// [RULE_14] trip inputs are synchronised; rising edge sets flag
module reset_cause_unit
   import rstcause_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic porRst,
   input wire logic sysRstIn,
   input wire bus_req_t busReq,
   output logic [31:0] rdata,
   input wire logic [`NCAUSE-1:0] causeEvent,
   input wire logic [`NRAIL-1:0] railTrip,
   input wire logic sleepEntry,
   input wire logic [`NPERIPH-1:0] periphRun,
   output logic [`NPERIPH-1:0] periphClkEn,
   output logic irq,
   output logic nmi,
   output rst_req_t rstReq
);
   // ===========================================================
   // state
   logic [`NCAUSE-1:0] cause_ff;
   logic [`NRAIL-1:0] vstat_ff;
   logic [5:0] vcfg_ff;
   logic [7:0] behav_ff;
   logic [`NRAIL-1:0] intEn_ff;
   logic [`NPERIPH-1:0] periphSlp_ff;
   logic gating_ff;
   logic asleep_ff;
   logic [`NRAIL-1:0] trip1_ff, trip2_ff, trip3_ff;
   logic [1:0] pulseCnt_ff;
   logic pulseFull_ff;
   logic rdValid_ff;
   logic [31:0] rdata_ff;
   logic [`NRAIL-1:0] tripRise;
   logic [`NRAIL-1:0] vstatSet;
   logic resetFire;
   logic fullPorPick;
   logic wrCauseClr, wrVstatClr, wrCfg, wrBehav, wrSwRst;
   logic wrSleep, wrIntEn, wrPeriph;

   // decode of a 2-bit behaviour field into full por or not
   function automatic logic pickFull(input logic [1:0] fld);
      pickFull = (fld == 2'b01) ? 1'b1 :
                 (fld == 2'b10) ? 1'b0 : `DEFAULT_FULL_POR;
   endfunction

   // ===========================================================
   // write decode
   always_comb begin
      wrCauseClr = busReq.wr && busReq.addr == `ADDR_CAUSE_CLR;
      wrVstatClr = busReq.wr && busReq.addr == `ADDR_VSTAT_CLR;
      wrCfg = busReq.wr && busReq.addr == `ADDR_VCFG;
      wrBehav = busReq.wr && busReq.addr == `ADDR_BEHAV;
      wrSwRst = busReq.wr && busReq.addr == `ADDR_SWRST && busReq.wdata[0];
      wrSleep = busReq.wr && busReq.addr == `ADDR_SLEEP;
      wrIntEn = busReq.wr && busReq.addr == `ADDR_INT_EN;
      wrPeriph = busReq.wr && busReq.addr == `ADDR_PERIPH_SLP;
   end

   // ===========================================================
   // trip synchronisers, three stages, edge on stages two and three
   always_ff @(posedge clk or posedge porRst) begin
      if (porRst) begin
         trip1_ff <= '0;
         trip2_ff <= '0;
         trip3_ff <= '0;
      end else begin
         trip1_ff <= railTrip;
         trip2_ff <= trip1_ff;
         trip3_ff <= trip2_ff;
      end
   end
   assign tripRise = trip2_ff & ~trip3_ff; // [RULE_14]

   // ===========================================================
   // brown-out flags: only por on the power domain, set beats clear
   assign vstatSet = tripRise; // [RULE_06]
   always_ff @(posedge clk or posedge porRst) begin
      if (porRst) begin
         vstat_ff <= '0;
      end else begin
         // clear by mask, new event wins [RULE_08] [RULE_07]
         vstat_ff <= (vstat_ff & ~({`NRAIL{wrVstatClr}}
                     & busReq.wdata[`NRAIL-1:0])) | vstatSet;
      end
   end

   // ===========================================================
   // cause flags: por clears all but the por flag, system resets leave them [RULE_01]
   always_ff @(posedge clk or posedge porRst) begin
      if (porRst) begin
         cause_ff <= '0;
         cause_ff[`CB_POR] <= 1'b1;
      end else begin
         // accumulate, mask clear, set wins [RULE_02] [RULE_03]
         cause_ff <= (cause_ff & ~({`NCAUSE{wrCauseClr}}
                     & busReq.wdata[`NCAUSE-1:0])) | causeEvent;
         if (wrSwRst) begin
            cause_ff[`CB_SW] <= 1'b1; // [RULE_13]
         end
         if (resetFire) begin
            cause_ff[`CB_BOR] <= 1'b1;
         end
      end
   end

   // ===========================================================
   // configuration, returned to defaults by any reset [RULE_13]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vcfg_ff <= `VCFG_RESET;
         behav_ff <= `BEHAV_RESET;
         intEn_ff <= '0;
         periphSlp_ff <= `PERIPH_SLP_RESET;
         gating_ff <= 1'b0;
      end else begin
         if (wrCfg) begin
            vcfg_ff <= busReq.wdata[5:0];
         end
         if (wrBehav) begin
            behav_ff <= busReq.wdata[7:0];
         end
         if (wrIntEn) begin
            intEn_ff <= busReq.wdata[`NRAIL-1:0];
         end
         if (wrPeriph) begin
            periphSlp_ff <= busReq.wdata[`NPERIPH-1:0];
         end
         if (wrSleep) begin
            gating_ff <= busReq.wdata[0];
         end
      end
   end

   // ===========================================================
   // sleep state: entered on request, left on any wake from running ones
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         asleep_ff <= 1'b0;
      end else if (sleepEntry) begin
         asleep_ff <= 1'b1;
      end else if (irq || nmi || |(periphRun & periphClkEn)) begin
         asleep_ff <= 1'b0;
      end
   end
   always_comb begin
      // gated sleep keeps only sleep-enabled peripherals [RULE_05]
      if (asleep_ff && gating_ff) begin
         periphClkEn = periphSlp_ff;
      end else begin
         periphClkEn = '1;
      end
   end

   // ===========================================================
   // rail responses
   always_comb begin
      resetFire = 1'b0;
      irq = 1'b0;
      nmi = 1'b0;
      // analogue rail response [RULE_09]
      unique case (rail_resp_t'(vcfg_ff[`VCFG_ANALOG_LSB +: 2]))
         RESP_NONE: ;
         RESP_IRQ: irq = irq | (vstat_ff[`RB_ANALOG] & intEn_ff[`RB_ANALOG]);
         RESP_NMI: nmi = nmi | vstat_ff[`RB_ANALOG];
         RESP_RESET: resetFire = resetFire | tripRise[`RB_ANALOG];
      endcase
      // main rail response [RULE_10]
      unique case (rail_resp_t'(vcfg_ff[`VCFG_MAIN_LSB +: 2]))
         RESP_NONE: ;
         RESP_IRQ: irq = irq | (vstat_ff[`RB_MAIN] & intEn_ff[`RB_MAIN]);
         RESP_NMI: nmi = nmi | vstat_ff[`RB_MAIN];
         RESP_RESET: resetFire = resetFire | tripRise[`RB_MAIN];
      endcase
      // core rail response
      unique case (rail_resp_t'(vcfg_ff[`VCFG_CORE_LSB +: 2]))
         RESP_NONE: ;
         RESP_IRQ: irq = irq | (vstat_ff[`RB_CORE] & intEn_ff[`RB_CORE]);
         RESP_NMI: nmi = nmi | vstat_ff[`RB_CORE];
         RESP_RESET: resetFire = resetFire | tripRise[`RB_CORE];
      endcase
   end

   // ===========================================================
   // reset kind selection [RULE_11] [RULE_12]
   always_comb begin
      fullPorPick = 1'b0;
      if (resetFire) begin
         fullPorPick = pickFull(behav_ff[`BH_BOR_LSB +: 2]);
      end else if (causeEvent[`CB_WDOG0]) begin
         fullPorPick = pickFull(behav_ff[`BH_WDOG0_LSB +: 2]);
      end else if (causeEvent[`CB_WDOG1]) begin
         fullPorPick = pickFull(behav_ff[`BH_WDOG1_LSB +: 2]);
      end else if (causeEvent[`CB_EXT]) begin
         fullPorPick = pickFull(behav_ff[`BH_EXT_LSB +: 2]);
      end else if (causeEvent[`CB_BOR]) begin
         fullPorPick = pickFull(behav_ff[`BH_BOR_LSB +: 2]);
      end
   end

   // reset request pulse, held a fixed count of cycles
   always_ff @(posedge clk or posedge porRst) begin
      if (porRst) begin
         pulseCnt_ff <= '0;
         pulseFull_ff <= 1'b0;
      end else if (pulseCnt_ff != 2'd0) begin
         pulseCnt_ff <= pulseCnt_ff - 2'd1;
      end else if (resetFire || wrSwRst || (|(causeEvent &
                   ((`NCAUSE'(1) << `CB_WDOG0) | (`NCAUSE'(1) << `CB_WDOG1)
                   | (`NCAUSE'(1) << `CB_EXT))))) begin
         pulseCnt_ff <= 2'(`RST_PULSE_CYC);
         pulseFull_ff <= wrSwRst ? 1'b0 : fullPorPick; // [RULE_12]
      end
   end
   assign rstReq.fullPor = (pulseCnt_ff != 2'd0) && pulseFull_ff;
   assign rstReq.sysReset = (pulseCnt_ff != 2'd0) && !pulseFull_ff;

   // ===========================================================
   // read port, data in the cycle after the strobe only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= '0;
         rdValid_ff <= 1'b0;
      end else begin
         rdValid_ff <= busReq.rd;
         rdata_ff <= '0;
         if (busReq.rd) begin
            unique case (busReq.addr)
               `ADDR_CAUSE: rdata_ff <= 32'(cause_ff);
               `ADDR_VSTAT: rdata_ff <= 32'(vstat_ff);
               `ADDR_VCFG: rdata_ff <= 32'(vcfg_ff);
               `ADDR_BEHAV: rdata_ff <= 32'(behav_ff);
               `ADDR_SLEEP: rdata_ff <= {30'h0, asleep_ff, gating_ff};
               `ADDR_INT_EN: rdata_ff <= 32'(intEn_ff);
               `ADDR_PERIPH_SLP: rdata_ff <= 32'(periphSlp_ff);
               default: rdata_ff <= 32'h0;
            endcase
         end
      end
   end
   assign rdata = rdValid_ff ? rdata_ff : 32'h0;

   // sysRstIn marks the system reset; it is joined onto rst outside
   logic unusedSys;
   assign unusedSys = sysRstIn;
endmodule

// *** logic/rstcause_defines.svh ***
// offsets, field positions, reset values and timing counts
`ifndef RSTCAUSE_DEFINES_SVH
`define RSTCAUSE_DEFINES_SVH
// register word offsets (byte address = offset)
`define ADDR_CAUSE 8'h00
`define ADDR_CAUSE_CLR 8'h04
`define ADDR_VSTAT 8'h08
`define ADDR_VSTAT_CLR 8'h0c
`define ADDR_VCFG 8'h10
`define ADDR_BEHAV 8'h14
`define ADDR_SWRST 8'h18
`define ADDR_SLEEP 8'h1c
`define ADDR_INT_EN 8'h20
`define ADDR_PERIPH_SLP 8'h24
// cause bit positions
`define CB_EXT 0
`define CB_POR 1
`define CB_BOR 2
`define CB_WDOG 3
`define CB_SW 4
`define CB_WDOG0 5
`define CB_WDOG1 6
`define CB_LDO 7
`define CB_HIB 8
`define CB_HSRV 9
`define NCAUSE 10
// rail bit positions
`define RB_MAIN 0
`define RB_ANALOG 1
`define RB_CORE 2
`define NRAIL 3
// config field positions: 2 bits per rail response
`define VCFG_ANALOG_LSB 0
`define VCFG_MAIN_LSB 2
`define VCFG_CORE_LSB 4
// behaviour fields: 2 bits each, 00 default, 01 full por, 10 system
`define BH_WDOG0_LSB 0
`define BH_WDOG1_LSB 2
`define BH_BOR_LSB 4
`define BH_EXT_LSB 6
`define BEHAV_RESET 8'h00
`define VCFG_RESET 6'h00
`define NPERIPH 16
`define PERIPH_SLP_RESET 16'h0000
// default reset kind when a behaviour field is unset: system reset
`define DEFAULT_FULL_POR 1'b0
// reset request pulse length
`define RST_PULSE_NS 100
`define CLK_PERIOD_NS 50
`define RST_PULSE_CYC ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** logic/rstcause_pkg.sv ***
// types shared by the reset-cause and brown-out block
package rstcause_pkg;
   typedef enum logic [1:0] {
      RESP_NONE,
      RESP_IRQ,
      RESP_NMI,
      RESP_RESET
   } rail_resp_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
   typedef struct packed {
      logic fullPor;
      logic sysReset;
   } rst_req_t;
endpackage

// *** testbench/reset_cause_monitor.sv ***
// checker bound to the reset-cause and brown-out block
`timescale 1ns/1ps
`include "rstcause_defines.svh"
module reset_cause_monitor import rstcause_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire bus_req_t busReq,
   input wire logic [31:0] rdata,
   input wire logic [`NCAUSE-1:0] causeEvent,
   input wire logic [`NRAIL-1:0] railTrip,
   input wire logic irq,
   input wire logic nmi,
   input wire rst_req_t rstReq
);
   // ==================================================
   // cycles since a bus write, trip change or cause pulse
   logic [3:0] quiet_ff;
   logic [`NRAIL-1:0] trip_ff;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         quiet_ff <= 4'hf;
         trip_ff <= '0;
      end else begin
         trip_ff <= railTrip;
         if (busReq.wr || railTrip != trip_ff || |causeEvent)
            quiet_ff <= 4'h0;
         else if (quiet_ff != 4'hf)
            quiet_ff <= quiet_ff + 4'h1;
      end
   end
   // ==================================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence twoThenLow(s);
      s [*2] ##1 !s;
   endsequence
   sequence soonWrite;
      $past(busReq.wr) || $past(busReq.wr, 2);
   endsequence
   chk_rdata_quiet: assert property (
      !$past(busReq.rd) |-> rdata == 32'h0) else $error("stray read data");
   chk_sys_pulse: assert property (
      $rose(rstReq.sysReset) |-> twoThenLow(rstReq.sysReset))
      else $error("system reset pulse length");
   chk_por_pulse: assert property (
      $rose(rstReq.fullPor) |-> twoThenLow(rstReq.fullPor))
      else $error("full por pulse length");
   chk_irq_cause: assert property (
      $rose(irq) |-> quiet_ff <= 4'h8) else $error("irq without cause");
   chk_nmi_cause: assert property (
      $rose(nmi) |-> quiet_ff <= 4'h8) else $error("nmi without cause");
   chk_reset_cause: assert property (
      $rose(rstReq.fullPor || rstReq.sysReset) |-> quiet_ff <= 4'h8)
      else $error("reset request without cause");
   chk_irq_drop: assert property (
      $fell(irq) |-> soonWrite) else $error("irq fell without write");
   chk_nmi_drop: assert property (
      $fell(nmi) |-> soonWrite) else $error("nmi fell without write");
endmodule
bind reset_cause_unit reset_cause_monitor reset_cause_monitor_inst (
   .clk(clk), .rst(rst), .busReq(busReq), .rdata(rdata),
   .causeEvent(causeEvent), .railTrip(railTrip), .irq(irq), .nmi(nmi),
   .rstReq(rstReq));

// *** testbench/tb_reset_cause_unit.sv ***
// self-checking bench for the reset-cause and brown-out block
`timescale 1ns/1ps
`include "rstcause_defines.svh"
module tb_reset_cause_unit import rstcause_pkg::*;;
   logic clk, rst, porRst, sleepEntry, irq, nmi;
   bus_req_t busReq;
   logic [31:0] rdata, cx, v, m;
   logic [`NCAUSE-1:0] causeEvent;
   logic [`NRAIL-1:0] railTrip;
   logic [`NPERIPH-1:0] periphClkEn;
   rst_req_t rstReq;
   logic [3:0] seen;
   int badCount, checksDone, b, b2, lsb;
   reset_cause_unit reset_cause_unit_inst (
      .clk(clk), .rst(rst), .porRst(porRst), .sysRstIn(1'b0),
      .busReq(busReq), .rdata(rdata), .causeEvent(causeEvent),
      .railTrip(railTrip), .sleepEntry(sleepEntry),
      .periphRun(16'h0000), .periphClkEn(periphClkEn),
      .irq(irq), .nmi(nmi), .rstReq(rstReq));
   // ==================================================
   // clock, helpers and bus tasks
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic tallyAndFinish();
      if (badCount == 0 && checksDone > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         badCount++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      busReq.addr <= a;
      busReq.rd <= 1'b1;
      @(posedge clk);
      busReq.rd <= 1'b0;
      #1 v = rdata;
      cmp(v, exp);
   endtask
   task automatic pulse(input int n);
      @(posedge clk);
      causeEvent[n] <= 1'b1;
      @(posedge clk);
      causeEvent <= '0;
   endtask
   task automatic watch(input int n);
      seen = 4'h0;
      repeat (n) begin
         @(posedge clk);
         #1 seen = seen | {irq, nmi, rstReq.fullPor, rstReq.sysReset};
      end
   endtask
   task automatic resetDut(input logic por);
      @(posedge clk);
      rst <= 1'b1;
      porRst <= por;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      porRst <= 1'b0;
   endtask
   task automatic sleepChk(input logic [15:0] exp);
      @(posedge clk) sleepEntry <= 1'b1;
      @(posedge clk) sleepEntry <= 1'b0;
      @(posedge clk);
      #1 cmp({16'h0, periphClkEn}, {16'h0, exp});
   endtask
   // expected irq, nmi, full por, system flags for a response
   function automatic logic [3:0] respExp(input int r, input int k);
      if (r == 3) return (k == 1) ? 4'b0010 : 4'b0001;
      return (r == 1) ? 4'b1000 : (r == 2) ? 4'b0100 : 4'b0000;
   endfunction
   initial begin
      #2000000 badCount++;
      tallyAndFinish();
   end
   // ==================================================
   // main sequence
   initial begin
      {rst, porRst, sleepEntry, causeEvent, railTrip} = '1;
      {sleepEntry, causeEvent, railTrip} = '0;
      busReq = '0;
      void'($urandom(42));
      resetDut(1'b1);
      cx = 32'h2;
      rd(`ADDR_CAUSE, cx);
      repeat (6) begin
         b = $urandom_range(0, 9);
         pulse(b);
         b2 = $urandom_range(0, 9);
         pulse(b2);
         cx = cx | (32'h1 << b) | (32'h1 << b2);
         m = $urandom & 32'h3ff;
         rd(`ADDR_CAUSE, cx);
         wr(`ADDR_CAUSE_CLR, m);
         cx = cx & ~m;
         rd(`ADDR_CAUSE, cx);
         pulse(b);
         cx = cx | (32'h1 << b);
         resetDut(1'b0);
         rd(`ADDR_CAUSE, cx);
      end
      wr(`ADDR_CAUSE_CLR, 32'h3ff);
      rd(`ADDR_CAUSE, 32'h0);
      wr(`ADDR_INT_EN, 32'h7);
      for (int r = 0; r < 3; r++) begin
         lsb = (r == 0) ? 2 : (r == 1) ? 0 : 4;
         for (int p = 0; p < 4; p++) for (int k = 0; k < 3; k++) begin
            if (p != 3 && k > 0) continue;
            @(posedge clk) railTrip <= '0;
            repeat (5) @(posedge clk);
            wr(`ADDR_VSTAT_CLR, 32'h7);
            wr(`ADDR_BEHAV, 32'(k) << `BH_BOR_LSB);
            wr(`ADDR_VCFG, 32'(p) << lsb);
            @(posedge clk) railTrip[r] <= 1'b1;
            watch(10);
            cmp({28'h0, seen}, {28'h0, respExp(p, k)});
            rd(`ADDR_VSTAT, 32'h1 << r);
            wr(`ADDR_VSTAT_CLR, 32'h7);
            rd(`ADDR_VSTAT, 32'h0);
         end
      end
      wr(`ADDR_VCFG, 32'h0);
      @(posedge clk) railTrip <= '0;
      repeat (5) @(posedge clk);
      @(posedge clk) railTrip <= '1;
      repeat (6) @(posedge clk);
      resetDut(1'b0);
      rd(`ADDR_VSTAT, 32'h7);
      m = $urandom_range(1, 6);
      wr(`ADDR_VSTAT_CLR, m);
      rd(`ADDR_VSTAT, 32'h7 & ~m);
      wr(`ADDR_VSTAT_CLR, 32'h7 & ~m);
      rd(`ADDR_VSTAT, 32'h0);
      wr(`ADDR_CAUSE_CLR, 32'h3ff);
      pulse(`CB_EXT);
      // let the pin reset pulse run out first
      repeat (4) @(posedge clk);
      wr(`ADDR_SWRST, 32'h1);
      watch(6);
      cmp({28'h0, seen}, 32'h1);
      resetDut(1'b0);
      rd(`ADDR_CAUSE, 32'h11);
      m = $urandom & 32'hffff;
      wr(`ADDR_PERIPH_SLP, m);
      wr(`ADDR_SLEEP, 32'h1);
      sleepChk(m[15:0]);
      resetDut(1'b0);
      wr(`ADDR_SLEEP, 32'h0);
      sleepChk(16'hffff);
      tallyAndFinish();
   end
endmodule
